// ===== pkg/dai_consts.vh
/*
 * Constants of the drive activity indicator: register map, field positions,
 * reset values and command opcodes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DAI_CONSTS_VH
`define DAI_CONSTS_VH

// Register word indices
`define DAI_REG_CTRL      4'h0
`define DAI_REG_PKT_FORCE 4'h1
`define DAI_REG_STATUS    4'h2
`define DAI_REG_PKT_STAT  4'h3

// Control register fields
`define DAI_CTRL_EMUL_BIT 0
`define DAI_CTRL_SIG_BIT  1
`define DAI_CTRL_OPC_BIT  2
`define DAI_CTRL_RESET    32'h0000_0006

// Packet command opcodes
`define DAI_OPC_PACKET    8'ha0
`define DAI_OPC_IDENT_PKT 8'ha1

// Wait states before the slave answers
`define DAI_BUS_WAIT      2'h1

`endif

// ===== hdl/dai_channel.v
/*
 * One channel of the drive activity indicator: packet device classification
 * and busy term.
 * Assumes inputs synchronous to clk_in and a clean asynchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none
`include "dai_consts.vh"

module dai_channel #(
	parameter TAGS = 32
) (
	input  wire            clk_in,
	input  wire            rstn_in,
	input  wire            clear_in,
	input  wire            bsy_in,
	input  wire [TAGS-1:0] sactive_in,
	input  wire            sig_valid_in,
	input  wire            sig_packet_in,
	input  wire            cmd_valid_in,
	input  wire [7:0]      cmd_opcode_in,
	input  wire            use_sig_in,
	input  wire            use_opc_in,
	input  wire            force_pkt_in,
	output reg             packet_out,
	output reg             busy_term_out
);

	reg next_packet;

	// Classify device from signature or opcode; software force only masks the busy term
	always @* begin
		next_packet = packet_out;
		if (use_sig_in && sig_valid_in)
			next_packet = sig_packet_in;
		if (use_opc_in && cmd_valid_in &&
		    (cmd_opcode_in == `DAI_OPC_PACKET || cmd_opcode_in == `DAI_OPC_IDENT_PKT))
			next_packet = 1'b1;
	end

	// Classification and registered busy term
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			packet_out    <= 1'b0;
			busy_term_out <= 1'b0;
		end else begin
			packet_out    <= clear_in ? 1'b0 : next_packet;
			// Packet devices never contribute activity
			busy_term_out <= (bsy_in || (|sactive_in)) &&
			                 !(next_packet || force_pkt_in);
		end
	end

endmodule // dai_channel

`default_nettype wire

// ===== hdl/dai_top.v
/*
 * Drive activity indicator top: channels, two-drive emulation secondary
 * term, open-drain activity outputs and Avalon-MM register slave.
 * Assumes all inputs synchronous to clk_in; pins resolved outside.
 */
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "dai_consts.vh"

module dai_top #(
	parameter CHANNELS = 4,
	parameter TAGS     = 32,
	parameter SEC_CH   = 1
) (
	input  wire                     clk_in,
	input  wire                     rstn_in,
	input  wire                     hardware_clear_in,
	input  wire [CHANNELS-1:0]      bsy_in,
	input  wire [CHANNELS*TAGS-1:0] sactive_in,
	input  wire [CHANNELS-1:0]      sig_valid_in,
	input  wire [CHANNELS-1:0]      sig_packet_in,
	input  wire [CHANNELS-1:0]      cmd_valid_in,
	input  wire [CHANNELS*8-1:0]    cmd_opcode_in,
	input  wire                     secondary_present_in,
	input  wire                     reg_fis_tx_in,
	input  wire [CHANNELS-1:0]      led_in,
	input  wire                     led_all_in,
	input  wire [3:0]               avs_address,
	input  wire                     avs_read,
	input  wire                     avs_write,
	input  wire [31:0]              avs_writedata,
	output reg  [31:0]              avs_readdata,
	output reg                      avs_waitrequest,
	output reg  [CHANNELS-1:0]      led_out,
	output reg  [CHANNELS-1:0]      led_oe_n_out,
	output reg                      led_all_out,
	output reg                      led_all_oe_n_out
);

	reg  [31:0]         ctrl;
	reg  [CHANNELS-1:0] pkt_force;
	reg                 secondary_term;
	reg                 clear_q;
	reg  [1:0]          wait_cnt;
	reg  [CHANNELS-1:0] next_act;
	reg  [31:0]         next_rdata;
	wire [CHANNELS-1:0] busy_term;
	wire [CHANNELS-1:0] packet;
	wire                clear_now;
	wire                emul_on;
	wire                bus_req;
	wire                bus_done;
	integer             i;

	// Power-on clear and hardware clear combine into one indicator reset
	assign clear_now = hardware_clear_in || clear_q;
	assign emul_on   = ctrl[`DAI_CTRL_EMUL_BIT];
	assign bus_req   = avs_read || avs_write;
	assign bus_done  = bus_req && (wait_cnt == `DAI_BUS_WAIT);

	// Power-on clear stretch: one cycle after async reset release
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			clear_q <= 1'b1;
		else
			clear_q <= 1'b0;
	end

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
			dai_channel #(
				.TAGS(TAGS)
			) u_ch (
				.clk_in        (clk_in),
				.rstn_in       (rstn_in),
				.clear_in      (clear_now),
				.bsy_in        (bsy_in[g]),
				.sactive_in    (sactive_in[g*TAGS +: TAGS]),
				.sig_valid_in  (sig_valid_in[g]),
				.sig_packet_in (sig_packet_in[g]),
				.cmd_valid_in  (cmd_valid_in[g]),
				.cmd_opcode_in (cmd_opcode_in[g*8 +: 8]),
				.use_sig_in    (ctrl[`DAI_CTRL_SIG_BIT]),
				.use_opc_in    (ctrl[`DAI_CTRL_OPC_BIT]),
				.force_pkt_in  (pkt_force[g]),
				.packet_out    (packet[g]),
				.busy_term_out (busy_term[g])
			);
		end
	endgenerate

	// Secondary term: set during reset, cleared by Register FIS on its channel
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			secondary_term <= 1'b0;
		else if (!(emul_on && secondary_present_in))
			secondary_term <= 1'b0;
		else if (clear_now)
			secondary_term <= 1'b1;
		else if (reg_fis_tx_in)
			secondary_term <= 1'b0;
	end

	// Per-channel activity: busy term OR secondary term on its channel
	always @* begin
		for (i = 0; i < CHANNELS; i = i + 1)
			next_act[i] = busy_term[i] || (secondary_term && (i == SEC_CH));
	end

	// Open-drain outputs, low while lit; enable low means driving
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			led_out          <= {CHANNELS{1'b1}};
			led_oe_n_out     <= {CHANNELS{1'b1}};
			led_all_out      <= 1'b1;
			led_all_oe_n_out <= 1'b1;
		end else begin
			led_out          <= {CHANNELS{1'b0}};
			led_oe_n_out     <= ~next_act;
			led_all_out      <= 1'b0;
			led_all_oe_n_out <= ~(|next_act);
		end
	end

	// Read mux
	always @* begin
		next_rdata = 32'h0000_0000;
		case (avs_address)
			`DAI_REG_CTRL:      next_rdata = ctrl;
			`DAI_REG_PKT_FORCE: next_rdata[CHANNELS-1:0] = pkt_force;
			`DAI_REG_STATUS: begin
				next_rdata[CHANNELS-1:0] = ~led_in;
				next_rdata[16]           = ~led_all_in;
				next_rdata[17]           = secondary_term;
			end
			`DAI_REG_PKT_STAT:  next_rdata[CHANNELS-1:0] = packet;
			default:            next_rdata = 32'h0000_0000;
		endcase
	end

	// Avalon-MM slave with one wait state
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl            <= `DAI_CTRL_RESET;
			pkt_force       <= {CHANNELS{1'b0}};
			wait_cnt        <= 2'h0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			if (bus_req && !bus_done && avs_waitrequest)
				wait_cnt <= wait_cnt + 2'h1;
			else
				wait_cnt <= 2'h0;
			avs_waitrequest <= !(bus_req && (wait_cnt + 2'h1 == `DAI_BUS_WAIT) &&
			                     avs_waitrequest);
			// Read data launched one edge early so it stands at completion
			if (bus_req && (wait_cnt + 2'h1 == `DAI_BUS_WAIT) && avs_waitrequest)
				avs_readdata <= next_rdata;
			// Writes land only at the completion edge, waitrequest low
			if (bus_req && !avs_waitrequest) begin
				if (avs_write && avs_address == `DAI_REG_CTRL)
					ctrl <= avs_writedata & 32'h0000_0007;
				if (avs_write && avs_address == `DAI_REG_PKT_FORCE)
					pkt_force <= avs_writedata[CHANNELS-1:0];
			end
		end
	end

endmodule // dai_top

`default_nettype wire

// ===== dv/dai_led_model.sv
/* Activity lines with pull-ups, as the LEDs see them.
   Assumes open-drain drive: enable low pulls the line. */
`timescale 1ns/1ns
`default_nettype none
module dai_led_model #(parameter N = 3) (
	input  wire logic [N-1:0] oe_n_in,
	input  wire logic [N-1:0] drv_in,
	output wire logic [N-1:0] lvl_out
);
	// Released line floats up to the pull-up
	assign lvl_out = oe_n_in | drv_in;
endmodule // dai_led_model
`default_nettype wire

// ===== dv/dai_chk.sv
/* Port checker for the activity indicator top.
   Assumes binding to dai_top. */
`timescale 1ns/1ns
`default_nettype none
module dai_chk #(parameter CHANNELS = 4, TAGS = 32, SEC_CH = 1) (
	input wire logic                     clk_in,
	input wire logic                     rstn_in,
	input wire logic                     hardware_clear_in,
	input wire logic [CHANNELS-1:0]      bsy_in,
	input wire logic [CHANNELS*TAGS-1:0] sactive_in,
	input wire logic                     reg_fis_tx_in,
	input wire logic                     avs_read,
	input wire logic                     avs_write,
	input wire logic [31:0]              avs_readdata,
	input wire logic                     avs_waitrequest,
	input wire logic [CHANNELS-1:0]      led_out,
	input wire logic [CHANNELS-1:0]      led_oe_n_out,
	input wire logic                     led_all_out,
	input wire logic                     led_all_oe_n_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Secondary channel quiet and out of reset
	wire q = !hardware_clear_in && !bsy_in[SEC_CH] && sactive_in[SEC_CH*TAGS+:TAGS] == 0;
	a_drive_low: assert property ($past(rstn_in) |-> (led_out == 0 && !led_all_out))
		else $error("activity level not low");
	a_aggr_or: assert property (led_all_oe_n_out == &led_oe_n_out)
		else $error("aggregate not OR of channels");
	a_idle_dark: assert property ((!bsy_in[0] && sactive_in[TAGS-1:0] == 0)[*2] |-> ##2 led_oe_n_out[0])
		else $error("idle channel lit");
	a_fis_clears: assert property (reg_fis_tx_in && q ##1 q[*3] |-> led_oe_n_out[SEC_CH])
		else $error("secondary lit after FIS");
	a_bus_answer: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("answer not one cycle late");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_idle_wait: assert property (!(avs_read | avs_write) |-> avs_waitrequest)
		else $error("answer without request");
	a_data_holds: assert property (!avs_waitrequest |=> $stable(avs_readdata))
		else $error("readdata changed after answer");
endmodule // dai_chk
bind dai_top dai_chk #(.CHANNELS(CHANNELS), .TAGS(TAGS), .SEC_CH(SEC_CH)) u_chk (.*);
`default_nettype wire

// ===== dv/tb_drive_activity_indicator.sv
/* Bench for the activity indicator, two channels.
   Assumes the LED model resolves the lines. */
`timescale 1ns/1ns
`default_nettype none
module tb_drive_activity_indicator;
	logic        clk_in = 0, rstn_in = 0, hardware_clear_in = 0, secondary_present_in = 0;
	logic        reg_fis_tx_in = 0, avs_read = 0, avs_write = 0;
	logic [1:0]  bsy_in = 0, sig_valid_in = 0, sig_packet_in = 0, cmd_valid_in = 0;
	logic [7:0]  sactive_in = 0;
	logic [15:0] cmd_opcode_in = 0;
	logic [3:0]  avs_address = 0;
	logic [31:0] avs_writedata = 0, r;
	wire  [31:0] avs_readdata;
	wire  [1:0]  led_out, led_oe_n_out;
	wire  [2:0]  lvl;
	wire         avs_waitrequest, led_all_out, led_all_oe_n_out;
	wire  [1:0]  led_in = lvl[1:0];
	wire         led_all_in = lvl[2];
	int          miscompares = 0, check_count = 0, seed = 5701, cyc = 0, i;
	dai_top #(.CHANNELS(2), .TAGS(4), .SEC_CH(1)) DUT (.*);
	dai_led_model u_led (.oe_n_in({led_all_oe_n_out, led_oe_n_out}),
		.drv_in({led_all_out, led_out}), .lvl_out(lvl));
	initial forever #10 clk_in = ~clk_in;
	// Hang guard
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	task tally_and_finish;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Line levels: low means lit
	function logic [2:0] lvl_of(input logic a0, input logic a1);
		return {~(a0 | a1), ~a1, ~a0};
	endfunction
	task see(input logic [2:0] e);
		repeat (4) @(posedge clk_in);
		chk({29'h0, lvl}, {29'h0, e});
	endtask
	// One bus access, held until waitrequest is seen low
	task xfer(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge clk_in);
		while (avs_waitrequest !== 1'b0) @(posedge clk_in);
		if (!w) chk(avs_readdata, e);
		avs_read <= 0;
		avs_write <= 0;
		@(posedge clk_in);
	endtask
	task pulse_clear;
		hardware_clear_in <= 1;
		@(posedge clk_in);
		hardware_clear_in <= 0;
	endtask
	initial begin
		repeat (2) @(posedge clk_in);
		rstn_in <= 1;
		@(posedge clk_in);
		xfer(0, 4'h0, 0, 32'h6);
		xfer(0, 4'hf, 0, 0);
		for (i = 0; i < 24; i++) begin
			r = $random(seed);
			bsy_in[0] <= r[0];
			sactive_in[3:0] <= r[4:1] & {4{r[5]}};
			see(lvl_of(r[0] | (r[5] & |r[4:1]), 0));
		end
		bsy_in[0] <= 0;
		sactive_in <= 0;
		cmd_opcode_in[15:8] <= 8'ha0;
		cmd_valid_in[1] <= 1;
		@(posedge clk_in);
		cmd_valid_in[1] <= 0;
		bsy_in[1] <= 1;
		see(lvl_of(0, 0));
		sig_valid_in[0] <= 1;
		sig_packet_in[0] <= 1;
		@(posedge clk_in);
		sig_valid_in[0] <= 0;
		bsy_in[0] <= 1;
		see(lvl_of(0, 0));
		xfer(0, 4'h3, 0, 32'h3);
		pulse_clear;
		see(lvl_of(1, 1));
		cmd_opcode_in[15:8] <= 8'ha1;
		cmd_valid_in[1] <= 1;
		@(posedge clk_in);
		cmd_valid_in[1] <= 0;
		see(lvl_of(1, 0));
		bsy_in <= 0;
		xfer(1, 4'h0, 32'h7, 0);
		secondary_present_in <= 1;
		hardware_clear_in <= 1;
		see(3'b001);
		hardware_clear_in <= 0;
		see(3'b001);
		reg_fis_tx_in <= 1;
		@(posedge clk_in);
		reg_fis_tx_in <= 0;
		see(3'h7);
		xfer(1, 4'h0, 32'h6, 0);
		pulse_clear;
		see(3'h7);
		// Software packet marking, status readback, detection switched off
		xfer(1, 4'h1, 32'h1, 0);
		bsy_in <= 2'b11;
		see(lvl_of(0, 1));
		xfer(0, 4'h1, 0, 32'h1);
		xfer(0, 4'h2, 0, 32'h0001_0002);
		xfer(1, 4'h1, 0, 0);
		xfer(1, 4'h0, 0, 0);
		cmd_opcode_in[7:0] <= 8'ha0;
		cmd_valid_in[0] <= 1;
		@(posedge clk_in);
		cmd_valid_in[0] <= 0;
		see(lvl_of(1, 1));
		xfer(0, 4'h3, 0, 0);
		tally_and_finish;
	end
endmodule // tb_drive_activity_indicator
`default_nettype wire
